// *** test/ifsb_periph_model.sv ***
// Stand-in for the peripherals that raise request lines.
// Assumes the bench pulses go for one cycle with the lines and a hold length.
`timescale 1ns/1ps
module ifsb_periph_model (
    input  wire logic        clk,
    input  wire logic        go,
    input  wire logic [14:0] fireVec,
    input  wire logic [1:0]  len,
    output logic      [14:0] reqVec
);
    logic [14:0] vec_q = 15'h0000;
    logic [1:0]  cnt_q = 2'h0;
    // A slow source holds its line for len cycles; each cycle that finds its flag already set counts as an overrun.
    always_ff @(posedge clk) begin
        if (cnt_q != 2'h0) begin
            cnt_q <= cnt_q - 2'h1;
        end else if (go) begin
            vec_q <= fireVec;
            cnt_q <= len;
        end
    end
    assign reqVec = (cnt_q != 2'h0) ? vec_q : 15'h0000;
endmodule : ifsb_periph_model

// *** test/ifsb_sva.sv ***
// Checker for the flag bank: request set, hold, clear and bus answers.
// Assumes it is bound to ifsb_top and sees only its ports.
`timescale 1ns/1ps
module ifsb_sva (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    input wire logic        irq,
    input wire logic        uartFirstTxReq,
    input wire logic        uartFirstTxFlag,
    input wire logic        uartFirstRxReq,
    input wire logic        uartFirstRxFlag,
    input wire logic        timerThirdReq,
    input wire logic        timerThirdFlag,
    input wire logic        timerSecondReq,
    input wire logic        timerSecondFlag
);
    default clocking cb @(posedge clk); endclocking
    wire logic wrAcc = psel && penable && pready && pwrite;
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence answer_s;
        pready ##1 !pready;
    endsequence
    tx_set_a: assert property (disable iff (reset) uartFirstTxReq |=> uartFirstTxFlag)
        else $error("uart tx flag not set");
    rx_set_a: assert property (disable iff (reset) uartFirstRxReq |=> uartFirstRxFlag)
        else $error("uart rx flag not set");
    t3_set_a: assert property (disable iff (reset) timerThirdReq |=> timerThirdFlag)
        else $error("timer three flag not set");
    t2_set_a: assert property (disable iff (reset) timerSecondReq |=> timerSecondFlag)
        else $error("timer two flag not set");
    flag_hold_a: assert property (disable iff (reset) uartFirstTxFlag && !wrAcc |=> uartFirstTxFlag)
        else $error("flag dropped without a write");
    flag_quiet_a: assert property (disable iff (reset)
        !timerSecondFlag && !timerSecondReq && !wrAcc |=> !timerSecondFlag)
        else $error("flag rose without a request");
    reset_clear_a: assert property (reset |=> !irq && !timerThirdFlag && !uartFirstRxFlag)
        else $error("outputs not cleared by reset");
    top_bit_a: assert property (disable iff (reset) pready && !pslverr |-> prdata[31:15] == 17'h00000)
        else $error("upper read bits not zero");
    bus_answer_a: assert property (disable iff (reset) setup_s |=> answer_s)
        else $error("access cycle not one wait-free cycle");
endmodule : ifsb_sva

bind ifsb_top ifsb_sva u_sva (.clk, .reset, .psel, .penable, .pwrite, .pready, .pslverr,
    .prdata, .irq, .uartFirstTxReq, .uartFirstTxFlag, .uartFirstRxReq, .uartFirstRxFlag,
    .timerThirdReq, .timerThirdFlag, .timerSecondReq, .timerSecondFlag);

// *** test/tb.sv ***
// Self-checking bench for the flag bank: APB master, sources and irq.
// Assumes an APB slave that answers in its own time; the run limit ends a hang.
`timescale 1ns/1ps
module tb;
    logic        clk, reset, psel, penable, pwrite, go, irq, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [14:0] reqVec, flagOut, fireVec;
    logic [1:0]  len;
    logic [3:0]  strb;
    int          failures, n_compared, cycles;

    ifsb_periph_model PEER (.clk, .go, .fireVec, .len, .reqVec);
    ifsb_top DUT (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(strb),
        .prdata, .pready, .pslverr, .irq, .extIrqZeroReq(reqVec[0]),
        .inCaptureFirstReq(reqVec[1]), .outCompareFirstReq(reqVec[2]),
        .timerFirstReq(reqVec[3]), .dmaCh0DoneReq(reqVec[4]), .inCaptureSecondReq(reqVec[5]),
        .outCompareSecondReq(reqVec[6]), .timerSecondReq(reqVec[7]),
        .timerThirdReq(reqVec[8]), .spiFirstErrorReq(reqVec[9]), .spiFirstEventReq(reqVec[10]),
        .uartFirstRxReq(reqVec[11]), .uartFirstTxReq(reqVec[12]),
        .adcFirstDoneReq(reqVec[13]), .dmaCh1DoneReq(reqVec[14]),
        .externalIrqZeroFlag(flagOut[0]), .inCaptureFirstFlag(flagOut[1]),
        .outCompareFirstFlag(flagOut[2]), .timerFirstFlag(flagOut[3]),
        .dmaCh0DoneFlag(flagOut[4]), .inCaptureSecondFlag(flagOut[5]),
        .outCompareSecondFlag(flagOut[6]), .timerSecondFlag(flagOut[7]),
        .timerThirdFlag(flagOut[8]), .spiFirstErrorFlag(flagOut[9]),
        .spiFirstEventFlag(flagOut[10]), .uartFirstRxFlag(flagOut[11]),
        .uartFirstTxFlag(flagOut[12]), .adcFirstDoneFlag(flagOut[13]),
        .dmaCh1DoneFlag(flagOut[14]));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic finish_test();
        $display("TB: compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            $display("MISMATCH t=%0t run did not complete", $time);
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // Request is held until pready is seen high at an edge, then released for
    // one idle cycle, so two calls never drive psel twice in one time step.
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string what);
        bus(1'b0, a, 32'h00000000);
        chk(rd, exp, what);
    endtask : rdchk

    task automatic fire(input logic [14:0] v, input logic [1:0] l);
        go      <= 1'b1;
        fireVec <= v;
        len     <= l;
        @(posedge clk);
        go <= 1'b0;
        repeat (l + 3) @(posedge clk);
    endtask : fire

    task automatic t_reset();
        rdchk(ifsb_pkg::OFS_FLAG, 32'h00000000, "flag after reset");
        rdchk(ifsb_pkg::OFS_MASK, 32'h00000000, "mask after reset");
        chk({17'h00000, flagOut}, 32'h00000000, "flag pins idle");
        $display("TB: reset test done");
    endtask : t_reset

    task automatic t_sources();
        for (int i = 0; i < 15; i++) begin
            fire(15'h0001 << i, 2'h1);
            chk({17'h00000, flagOut}, 32'h00000001 << i, "flag pin");
            rdchk(ifsb_pkg::OFS_FLAG, 32'h00000001 << i, "flag reg");
            bus(1'b1, ifsb_pkg::OFS_FLAG, 32'h00000000);
            rdchk(ifsb_pkg::OFS_FLAG, 32'h00000000, "flag cleared");
        end
        fire(15'h1980, 2'h3);
        repeat (8) @(posedge clk);
        chk({17'h00000, flagOut}, 32'h00001980, "uart and timer flags");
        $display("TB: source test done");
    endtask : t_sources

    task automatic t_write();
        bus(1'b1, ifsb_pkg::OFS_FLAG, 32'h0000FFFF);
        rdchk(ifsb_pkg::OFS_FLAG, 32'h00007FFF, "top bit stays zero");
        bus(1'b1, ifsb_pkg::OFS_FLAG, 32'h00008000);
        rdchk(ifsb_pkg::OFS_FLAG, 32'h00000000, "write zero clears");
        $display("TB: write test done");
    endtask : t_write

    task automatic t_irq();
        bus(1'b1, ifsb_pkg::OFS_ISTAT, 32'h00007FFF);
        bus(1'b1, ifsb_pkg::OFS_MASK, 32'h00000080);
        fire(15'h0100, 2'h1);
        chk({31'h00000000, irq}, 32'h00000000, "masked source quiet");
        fire(15'h0080, 2'h1);
        chk({31'h00000000, irq}, 32'h00000001, "unmasked source raises");
        bus(1'b1, ifsb_pkg::OFS_ISTAT, 32'h00000080);
        repeat (3) @(posedge clk);
        chk({31'h00000000, irq}, 32'h00000000, "status clear drops irq");
        rdchk(ifsb_pkg::OFS_FLAG, 32'h00000180, "flags kept");
        $display("TB: irq test done");
    endtask : t_irq

    task automatic t_unmapped();
        bus(1'b0, 12'h100, 32'h00000000);
        chk({31'h00000000, err}, 32'h00000001, "unmapped read error");
        chk(rd, 32'h00000000, "unmapped read data");
        bus(1'b1, 12'h001, 32'h00000000);
        chk({31'h00000000, err}, 32'h00000001, "unaligned write error");
        rdchk(ifsb_pkg::OFS_FLAG, 32'h00000180, "flags untouched");
        $display("TB: unmapped test done");
    endtask : t_unmapped

    task automatic t_aux();
        rdchk(ifsb_pkg::OFS_OVRN, 32'h00001980, "overrun kept");
        bus(1'b1, ifsb_pkg::OFS_OVRN, 32'h00007FFF);
        rdchk(ifsb_pkg::OFS_OVRN, 32'h00000000, "overrun cleared");
        fire(15'h0100, 2'h2);
        rdchk(ifsb_pkg::OFS_OVRN, 32'h00000100, "overrun on set flag");
        bus(1'b1, ifsb_pkg::OFS_FCLR, 32'h00000180);
        rdchk(ifsb_pkg::OFS_FLAG, 32'h00000000, "clear by one");
        bus(1'b1, ifsb_pkg::OFS_FSET, 32'h00000001);
        rdchk(ifsb_pkg::OFS_FSET, 32'h00000001, "set by one");
        strb <= 4'h2;
        bus(1'b1, ifsb_pkg::OFS_FLAG, 32'h0000FF00);
        strb <= 4'hF;
        rdchk(ifsb_pkg::OFS_FLAG, 32'h00007F01, "upper lane only");
        bus(1'b1, ifsb_pkg::OFS_RAW, 32'h00007FFF);
        chk({31'h00000000, err}, 32'h00000000, "raw write no error");
        rdchk(ifsb_pkg::OFS_RAW, 32'h00000000, "raw idle");
        $display("TB: aux test done");
    endtask : t_aux

    initial begin
        reset   = 1'b1;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h00000000;
        go      = 1'b0;
        fireVec = 15'h0000;
        len     = 2'h0;
        strb    = 4'hF;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_reset();
        t_sources();
        t_write();
        t_irq();
        t_unmapped();
        t_aux();
        finish_test();
    end
endmodule : tb

// *** verilog/ifsb_apb_port.sv ***
// APB handshake for the flag bank: no wait states, error on unmapped address.
// Assumes the master keeps the request stable until pready is seen high.
`timescale 1ns/1ps
module ifsb_apb_port (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic psel,
    input  wire logic penable,
    input  wire logic pwrite,
    input  wire logic mapped,
    output logic      pready,
    output logic      pslverr,
    output logic      setupCycle,
    output logic      wrCommit
);

    logic pready_q;
    logic pslverr_q;

    assign setupCycle = psel & ~penable;
    assign wrCommit   = psel & penable & pready_q & pwrite & ~pslverr_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= setupCycle;
            pslverr_q <= setupCycle & ~mapped;
        end
    end

    assign pready  = pready_q;
    assign pslverr = pslverr_q;

endmodule : ifsb_apb_port

// *** verilog/ifsb_pkg.sv ***
// Constants shared by the interrupt flag status bank and its helpers.
// Assumes a 32-bit APB bus and single-cycle request pulses from on-chip logic.
// Behaviour
// R1 - Transmit request of the first UART sets flag bit 12.
// R2 - Receive request of the first UART sets flag bit 11.
// R3 - Third timer request sets flag bit 8.
// R4 - Second timer request sets flag bit 7.
// R5 - A flag reads one after its request and holds until cleared.
// R6 - A flag reads zero while no request arrived since its last clear; a software write of one at OFS_FLAG or OFS_FSET also sets it.
// R7 - Flags reset to zero, software clears by writing zero, bit 15 reads zero.
package ifsb_pkg;

    localparam int          FLAG_W      = 16;
    localparam int          DATA_W      = 32;
    localparam int          ADDR_W      = 12;
    localparam int          STRB_W      = 4;

    localparam logic [11:0] OFS_FLAG    = 12'h000;
    localparam logic [11:0] OFS_MASK    = 12'h004;
    localparam logic [11:0] OFS_ISTAT   = 12'h008;
    localparam logic [11:0] OFS_OVRN    = 12'h00C;
    localparam logic [11:0] OFS_RAW     = 12'h010;
    localparam logic [11:0] OFS_FSET    = 12'h014;
    localparam logic [11:0] OFS_FCLR    = 12'h018;

    localparam logic [15:0] FLAG_RESET  = 16'h0000;
    localparam logic [15:0] MASK_RESET  = 16'h0000;
    localparam logic [15:0] IMPL_BITS   = 16'h7FFF;

    localparam int          BIT_EXT0    = 0;
    localparam int          BIT_ICAP1   = 1;
    localparam int          BIT_OCMP1   = 2;
    localparam int          BIT_TMR1    = 3;
    localparam int          BIT_DMA0    = 4;
    localparam int          BIT_ICAP2   = 5;
    localparam int          BIT_OCMP2   = 6;
    localparam int          BIT_TMR2    = 7;
    localparam int          BIT_TMR3    = 8;
    localparam int          BIT_SPIERR  = 9;
    localparam int          BIT_SPIEVT  = 10;
    localparam int          BIT_UARTRX  = 11;
    localparam int          BIT_UARTTX  = 12;
    localparam int          BIT_ADC     = 13;
    localparam int          BIT_DMA1    = 14;

endpackage : ifsb_pkg

// *** verilog/ifsb_sticky_bank.sv ***
// A bank of sticky bits with hardware set, software write and software clear.
// Assumes all inputs come from logic on the same clock.
`timescale 1ns/1ps
module ifsb_sticky_bank #(
    parameter int          WIDTH = 16,
    parameter logic [15:0] IMPL  = 16'hFFFF,
    parameter logic [15:0] INIT  = 16'h0000
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] setVec,
    input  wire logic [WIDTH-1:0] clrVec,
    input  wire logic [WIDTH-1:0] wrMask,
    input  wire logic [WIDTH-1:0] wrData,
    output logic      [WIDTH-1:0] bits
);

    logic      [WIDTH-1:0] bits_q;
    wire logic [WIDTH-1:0] bits_d;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            // Set is applied last so an event in the clearing cycle is kept.
            wire logic wrVal = wrMask[i] ? wrData[i] : bits_q[i];
            assign bits_d[i] = IMPL[i] & (setVec[i] | (wrVal & ~clrVec[i]));
        end
    endgenerate

    // One register process for the whole bank keeps a single driver per variable.
    always_ff @(posedge clk) begin
        if (reset) begin
            bits_q <= INIT[WIDTH-1:0];
        end else begin
            bits_q <= bits_d;
        end
    end

    assign bits = bits_q;

endmodule : ifsb_sticky_bank

// *** verilog/ifsb_top.sv ***
// Interrupt flag status bank zero with its APB slave and interrupt output.
// Assumes request inputs are synchronous pulses or levels from peripherals
// on clk, and an APB master on the same clock.
`timescale 1ns/1ps
module ifsb_top #(
    parameter int ADDR_W = ifsb_pkg::ADDR_W
) (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   irq,
    input  wire logic              extIrqZeroReq,
    input  wire logic              inCaptureFirstReq,
    input  wire logic              outCompareFirstReq,
    input  wire logic              timerFirstReq,
    input  wire logic              dmaCh0DoneReq,
    input  wire logic              inCaptureSecondReq,
    input  wire logic              outCompareSecondReq,
    input  wire logic              timerSecondReq,
    input  wire logic              timerThirdReq,
    input  wire logic              spiFirstErrorReq,
    input  wire logic              spiFirstEventReq,
    input  wire logic              uartFirstRxReq,
    input  wire logic              uartFirstTxReq,
    input  wire logic              adcFirstDoneReq,
    input  wire logic              dmaCh1DoneReq,
    output logic                   externalIrqZeroFlag,
    output logic                   inCaptureFirstFlag,
    output logic                   outCompareFirstFlag,
    output logic                   timerFirstFlag,
    output logic                   dmaCh0DoneFlag,
    output logic                   inCaptureSecondFlag,
    output logic                   outCompareSecondFlag,
    output logic                   timerSecondFlag,
    output logic                   timerThirdFlag,
    output logic                   spiFirstErrorFlag,
    output logic                   spiFirstEventFlag,
    output logic                   uartFirstRxFlag,
    output logic                   uartFirstTxFlag,
    output logic                   adcFirstDoneFlag,
    output logic                   dmaCh1DoneFlag
);

    localparam int W = ifsb_pkg::FLAG_W;

    logic [W-1:0]  reqVec;
    logic [W-1:0]  flags;
    logic [W-1:0]  intMask;
    logic [W-1:0]  intStat;
    logic [W-1:0]  overrun;
    logic [W-1:0]  rawReq_q;
    logic [31:0]   prdata_q;
    logic          irq_q;
    logic          setupCycle;
    logic          wrCommit;

    // Bit 15 has no source and is tied low.
    assign reqVec[15]                    = 1'b0; // R7
    assign reqVec[ifsb_pkg::BIT_EXT0]    = extIrqZeroReq;
    assign reqVec[ifsb_pkg::BIT_ICAP1]   = inCaptureFirstReq;
    assign reqVec[ifsb_pkg::BIT_OCMP1]   = outCompareFirstReq;
    assign reqVec[ifsb_pkg::BIT_TMR1]    = timerFirstReq;
    assign reqVec[ifsb_pkg::BIT_DMA0]    = dmaCh0DoneReq;
    assign reqVec[ifsb_pkg::BIT_ICAP2]   = inCaptureSecondReq;
    assign reqVec[ifsb_pkg::BIT_OCMP2]   = outCompareSecondReq;
    assign reqVec[ifsb_pkg::BIT_TMR2]    = timerSecondReq; // R4
    assign reqVec[ifsb_pkg::BIT_TMR3]    = timerThirdReq; // R3
    assign reqVec[ifsb_pkg::BIT_SPIERR]  = spiFirstErrorReq;
    assign reqVec[ifsb_pkg::BIT_SPIEVT]  = spiFirstEventReq;
    assign reqVec[ifsb_pkg::BIT_UARTRX]  = uartFirstRxReq; // R2
    assign reqVec[ifsb_pkg::BIT_UARTTX]  = uartFirstTxReq; // R1
    assign reqVec[ifsb_pkg::BIT_ADC]     = adcFirstDoneReq;
    assign reqVec[ifsb_pkg::BIT_DMA1]    = dmaCh1DoneReq;

    // Address decode.  Only word-aligned addresses are mapped.
    wire logic        aligned = (paddr[1:0] == 2'b00);
    wire logic [11:0] addr12  = 12'(paddr);
    wire logic        hitFlag = aligned & (addr12 == ifsb_pkg::OFS_FLAG);
    wire logic        hitMask = aligned & (addr12 == ifsb_pkg::OFS_MASK);
    wire logic        hitStat = aligned & (addr12 == ifsb_pkg::OFS_ISTAT);
    wire logic        hitOvrn = aligned & (addr12 == ifsb_pkg::OFS_OVRN);
    wire logic        hitRaw  = aligned & (addr12 == ifsb_pkg::OFS_RAW);
    wire logic        hitFset = aligned & (addr12 == ifsb_pkg::OFS_FSET);
    wire logic        hitFclr = aligned & (addr12 == ifsb_pkg::OFS_FCLR);
    wire logic        mapped  = hitFlag | hitMask | hitStat | hitOvrn
                              | hitRaw | hitFset | hitFclr;

    // Byte lanes 0 and 1 carry the 16 register bits; lanes 2 and 3 are ignored.
    wire logic [W-1:0] laneMask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    wire logic [W-1:0] wrBits   = pwdata[W-1:0] & laneMask;
    wire logic [W-1:0] zeroVec  = 16'h0000;

    wire logic [W-1:0] flagWrMask = (wrCommit & hitFlag) ? laneMask : zeroVec;
    wire logic [W-1:0] maskWrMask = (wrCommit & hitMask) ? laneMask : zeroVec;
    wire logic [W-1:0] flagSetSw  = (wrCommit & hitFset) ? wrBits : zeroVec;
    wire logic [W-1:0] flagClrSw  = (wrCommit & hitFclr) ? wrBits : zeroVec;
    wire logic [W-1:0] statClrSw  = (wrCommit & hitStat) ? wrBits : zeroVec;
    wire logic [W-1:0] ovrnClrSw  = (wrCommit & hitOvrn) ? wrBits : zeroVec;

    // A request that meets an already set flag is remembered as an overrun,
    // so software can tell that it has missed at least one event.
    wire logic [W-1:0] lostReq    = reqVec & flags;
    wire logic [W-1:0] flagSet    = reqVec | flagSetSw;

    ifsb_apb_port u_apb (
        .clk        (clk),
        .reset      (reset),
        .psel       (psel),
        .penable    (penable),
        .pwrite     (pwrite),
        .mapped     (mapped),
        .pready     (pready),
        .pslverr    (pslverr),
        .setupCycle (setupCycle),
        .wrCommit   (wrCommit)
    );

    // Flags are set by their sources, kept until cleared, and software
    // clears a bit by writing zero to it through the plain flag offset.
    ifsb_sticky_bank #(
        .WIDTH  (W),
        .IMPL   (ifsb_pkg::IMPL_BITS),
        .INIT   (ifsb_pkg::FLAG_RESET)
    ) u_flags (
        .clk    (clk),
        .reset  (reset), // R7
        .setVec (flagSet), // R5
        .clrVec (flagClrSw), // R6
        .wrMask (flagWrMask), // R7
        .wrData (wrBits),
        .bits   (flags)
    );

    ifsb_sticky_bank #(
        .WIDTH  (W),
        .IMPL   (ifsb_pkg::IMPL_BITS),
        .INIT   (ifsb_pkg::MASK_RESET)
    ) u_mask (
        .clk    (clk),
        .reset  (reset),
        .setVec (zeroVec),
        .clrVec (zeroVec),
        .wrMask (maskWrMask),
        .wrData (wrBits),
        .bits   (intMask)
    );

    ifsb_sticky_bank #(
        .WIDTH  (W),
        .IMPL   (ifsb_pkg::IMPL_BITS),
        .INIT   (ifsb_pkg::FLAG_RESET)
    ) u_stat (
        .clk    (clk),
        .reset  (reset),
        .setVec (reqVec),
        .clrVec (statClrSw),
        .wrMask (zeroVec),
        .wrData (zeroVec),
        .bits   (intStat)
    );

    ifsb_sticky_bank #(
        .WIDTH  (W),
        .IMPL   (ifsb_pkg::IMPL_BITS),
        .INIT   (ifsb_pkg::FLAG_RESET)
    ) u_ovrn (
        .clk    (clk),
        .reset  (reset),
        .setVec (lostReq),
        .clrVec (ovrnClrSw),
        .wrMask (zeroVec),
        .wrData (zeroVec),
        .bits   (overrun)
    );

    // Read selection.  Unused upper bits and unmapped offsets read zero.
    wire logic [W-1:0] rdSel =
          hitFlag ? flags
        : hitMask ? intMask
        : hitStat ? intStat
        : hitOvrn ? overrun
        : hitRaw  ? rawReq_q
        : hitFset ? flags
        : hitFclr ? flags
        : zeroVec;
    wire logic [31:0]  rdWord  = {16'h0000, rdSel};
    wire logic         irqNext = |(intStat & intMask);

    // Read data is captured at the setup edge so that it is stable for the
    // whole access phase; a flag set during that phase shows on the next read.
    always_ff @(posedge clk) begin
        if (reset) begin
            prdata_q <= 32'h0000_0000;
        end else if (setupCycle & ~pwrite) begin
            prdata_q <= rdWord;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            irq_q    <= 1'b0;
            rawReq_q <= 16'h0000;
        end else begin
            irq_q    <= irqNext;
            rawReq_q <= reqVec;
        end
    end

    assign prdata = prdata_q;
    assign irq    = irq_q;

    // Per-source flag outputs come straight from the flag flip-flops.
    assign externalIrqZeroFlag  = flags[ifsb_pkg::BIT_EXT0];
    assign inCaptureFirstFlag   = flags[ifsb_pkg::BIT_ICAP1];
    assign outCompareFirstFlag  = flags[ifsb_pkg::BIT_OCMP1];
    assign timerFirstFlag       = flags[ifsb_pkg::BIT_TMR1];
    assign dmaCh0DoneFlag       = flags[ifsb_pkg::BIT_DMA0];
    assign inCaptureSecondFlag  = flags[ifsb_pkg::BIT_ICAP2];
    assign outCompareSecondFlag = flags[ifsb_pkg::BIT_OCMP2];
    assign timerSecondFlag      = flags[ifsb_pkg::BIT_TMR2];
    assign timerThirdFlag       = flags[ifsb_pkg::BIT_TMR3];
    assign spiFirstErrorFlag    = flags[ifsb_pkg::BIT_SPIERR];
    assign spiFirstEventFlag    = flags[ifsb_pkg::BIT_SPIEVT];
    assign uartFirstRxFlag      = flags[ifsb_pkg::BIT_UARTRX];
    assign uartFirstTxFlag      = flags[ifsb_pkg::BIT_UARTTX];
    assign adcFirstDoneFlag     = flags[ifsb_pkg::BIT_ADC];
    assign dmaCh1DoneFlag       = flags[ifsb_pkg::BIT_DMA1];

endmodule : ifsb_top
